// [rtl/scu_cfg.svh]
/*
 Offsets, field positions, reset values and timing counts for the
 serial and companding control bits. Definitions only; included by
 the control bank.
*/
`ifndef SCU_CFG_SVH
`define SCU_CFG_SVH

// I/O port addresses seen on the write cycle
`define SCU_PORT_LOWER 3'h0
`define SCU_PORT_UPPER 3'h1

// Field positions in the full 32-bit control word
`define SCU_BIT_PORT1_SEL 8
`define SCU_BIT_SERIAL_EN 11
`define SCU_BIT_ENC_EN 12
`define SCU_BIT_DEC_EN 13
`define SCU_BIT_ALAW 14
`define SCU_BIT_SCLK_IN 15
`define SCU_FRAME_DIV_LSB 16
`define SCU_FRAME_DIV_MSB 23
`define SCU_PRESCALE_LSB 24
`define SCU_PRESCALE_MSB 27
`define SCU_BIT_PULSE_WIDE 28
`define SCU_BIT_TWOS 29
`define SCU_BIT_WORD16 30
`define SCU_BIT_RESERVED 31

// Reset image of bits 31..12: serial clock is an input, rest clear
`define SCU_CTRL_RESET 20'h00008

// Frame pulse length in variable data-rate mode, in serial clocks
`define SCU_WIDE_PULSE_CLKS 9'h008
// Frame period adds this to the frame divide count
`define SCU_FRAME_EXTRA 9'h002

`endif

// [rtl/scu_pkg.sv]
/*
 Types shared by the serial and companding control bank.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package scu_pkg;
   typedef logic [7:0] scu_frame_count_t;
   typedef logic [3:0] scu_prescale_t;
   typedef enum logic {SCU_LAW_MU, SCU_LAW_A} scu_law_t;
   typedef enum logic {SCU_CLK_INTERNAL, SCU_CLK_EXTERNAL} scu_clk_src_t;
endpackage

// [rtl/scu_sync.sv]
/*
 Three-flop pin synchroniser with agreement filter, any width.
 Assumes asynchronous pins and one receiving clock.
*/
`timescale 1ns/1ps
module scu_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clk_in, // system clock
   input wire logic rstn_in, // async reset, active low
   input wire logic [WIDTH-1:0] pin_in, // raw pin levels
   output logic [WIDTH-1:0] level_out // filtered level
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         meta <= RESET_VAL;
         stage2 <= RESET_VAL;
         stage3 <= RESET_VAL;
      end else begin
         meta <= pin_in;
         stage2 <= meta;
         stage3 <= stage2;
      end
   end

   // A bit moves only once the last two stages agree
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         level_out <= RESET_VAL;
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (stage2[i] == stage3[i]) begin
               level_out[i] <= stage3[i];
            end
         end
      end
   end
endmodule

// [rtl/scu_ctrl.sv]
/*
 Upper control bits (12..31) of the system control register, with the
 serial clock prescaler and the internal frame pulse generator.
 Assumes: the lower control register lives elsewhere and supplies its
 port-1 select and serial-enable bits; the companding and serial shift
 datapaths live elsewhere and take the settings and routed words below.
*/
`timescale 1ns/1ps
`include "scu_cfg.svh"
module scu_ctrl #(
   parameter int DATA_W = 16,
   // Half-period of the generated serial clock, in system clocks, per code
   parameter logic [16*8-1:0] PRESCALE_HALF = {
      8'h80, 8'h40, 8'h20, 8'h18, 8'h10, 8'h0e, 8'h0c, 8'h0a,
      8'h09, 8'h08, 8'h07, 8'h06, 8'h05, 8'h04, 8'h02, 8'h01}
) (
   input wire logic clk_in, // system clock, 50 MHz
   input wire logic rstn_in, // async reset, active low
   input wire logic we_n_in, // write strobe pin, active low
   input wire logic [2:0] port_in, // I/O port address pins
   input wire logic [DATA_W-1:0] data_in, // external data bus
   input wire logic port1_sel_in, // lower register bit 8
   input wire logic serial_en_in, // lower register bit 11
   input wire logic sclk_in, // serial clock pin, input side
   output logic sclk_out, // serial clock pin, output side
   output logic sclk_oe_out, // serial clock pin drive enable
   output logic internal_frame_pulse_out, // internal frame pulse
   output logic [19:0] ctrl_upper_out, // control bits 31..12
   output logic enc_en_out, // compress port 1 writes
   output logic dec_en_out, // expand port 1 reads
   output logic alaw_out, // 1 A-law, 0 mu-255 law
   output logic twos_out, // 1 two's complement companding
   output logic word16_out, // coprocessor word transfers
   output logic parallel_mode_out, // parallel companding mode
   output logic codec_wr_out, // port 1 word for serial/compander
   output logic [DATA_W-1:0] codec_data_out // routed port 1 word
);
   localparam int SYNC_W = DATA_W + 4;

   logic [SYNC_W-1:0] bus_lvl;
   logic we_n_lvl;
   logic we_n_prev;
   logic [2:0] port_lvl;
   logic [DATA_W-1:0] data_lvl;
   logic wr_done;
   logic [19:0] ctrl;
   logic sclk_ext_lvl;
   logic sclk_ext_prev;
   logic [7:0] half_count;
   logic [7:0] half_lim;
   logic int_tick;
   logic ser_tick;
   logic [8:0] frame_pos;
   logic [8:0] frame_last;
   logic [8:0] next_frame_pos;
   scu_pkg::scu_frame_count_t frame_divide_count;
   scu_pkg::scu_prescale_t prescale_code;
   scu_pkg::scu_clk_src_t clk_src;

   scu_sync #(
      .WIDTH(SYNC_W),
      .RESET_VAL({1'b1, {(SYNC_W - 1){1'b0}}})
   ) u_bus_sync (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .pin_in({we_n_in, port_in, data_in}),
      .level_out(bus_lvl)
   );

   scu_sync #(
      .WIDTH(1),
      .RESET_VAL(1'b0)
   ) u_sclk_sync (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .pin_in(sclk_in),
      .level_out(sclk_ext_lvl)
   );

   assign we_n_lvl = bus_lvl[SYNC_W-1];
   assign port_lvl = bus_lvl[DATA_W+2:DATA_W];
   assign data_lvl = bus_lvl[DATA_W-1:0];
   assign wr_done = we_n_lvl & ~we_n_prev;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         we_n_prev <= 1'b1;
      end else begin
         we_n_prev <= we_n_lvl;
      end
   end

   // Control word bits 31..12; ctrl[k] is control bit k+12
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ctrl <= `SCU_CTRL_RESET;
      end else if (wr_done && port_lvl == `SCU_PORT_LOWER) begin
         ctrl[3:0] <= data_lvl[`SCU_BIT_SCLK_IN:`SCU_BIT_ENC_EN];
      end else if (wr_done && port_lvl == `SCU_PORT_UPPER && port1_sel_in) begin
         ctrl[19:4] <= data_lvl[15:0];
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         codec_wr_out <= 1'b0;
         codec_data_out <= '0;
      end else begin
         codec_wr_out <= wr_done && port_lvl == `SCU_PORT_UPPER && !port1_sel_in;
         if (wr_done && port_lvl == `SCU_PORT_UPPER && !port1_sel_in) begin
            codec_data_out <= data_lvl;
         end
      end
   end

   // Settings handed to the companding and coprocessor logic
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ctrl_upper_out <= `SCU_CTRL_RESET;
         enc_en_out <= 1'b0;
         dec_en_out <= 1'b0;
         alaw_out <= 1'b0;
         twos_out <= 1'b0;
         word16_out <= 1'b0;
         parallel_mode_out <= 1'b1;
      end else begin
         ctrl_upper_out <= ctrl;
         enc_en_out <= ctrl[`SCU_BIT_ENC_EN-12];
         dec_en_out <= ctrl[`SCU_BIT_DEC_EN-12];
         alaw_out <= ctrl[`SCU_BIT_ALAW-12];
         twos_out <= ctrl[`SCU_BIT_TWOS-12];
         word16_out <= ctrl[`SCU_BIT_WORD16-12];
         parallel_mode_out <= ~serial_en_in;
      end
   end

   assign clk_src = ctrl[`SCU_BIT_SCLK_IN-12] ? scu_pkg::SCU_CLK_EXTERNAL
                                              : scu_pkg::SCU_CLK_INTERNAL;
   assign prescale_code = ctrl[`SCU_PRESCALE_MSB-12:`SCU_PRESCALE_LSB-12];
   assign frame_divide_count = ctrl[`SCU_FRAME_DIV_MSB-12:`SCU_FRAME_DIV_LSB-12];
   assign half_lim = PRESCALE_HALF[prescale_code*8 +: 8];

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         half_count <= 8'h00;
         sclk_out <= 1'b0;
      end else if (clk_src == scu_pkg::SCU_CLK_EXTERNAL) begin
         half_count <= 8'h00;
         sclk_out <= 1'b0;
      end else if (half_count >= half_lim - 8'h01) begin
         half_count <= 8'h00;
         sclk_out <= ~sclk_out;
      end else begin
         half_count <= half_count + 8'h01;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sclk_oe_out <= 1'b0;
         sclk_ext_prev <= 1'b0;
      end else begin
         sclk_oe_out <= clk_src == scu_pkg::SCU_CLK_INTERNAL;
         sclk_ext_prev <= sclk_ext_lvl;
      end
   end

   assign int_tick = clk_src == scu_pkg::SCU_CLK_INTERNAL && !sclk_out
                     && half_count >= half_lim - 8'h01;
   assign ser_tick = clk_src == scu_pkg::SCU_CLK_EXTERNAL ? sclk_ext_lvl & ~sclk_ext_prev
                                                        : int_tick;

   assign frame_last = {1'b0, frame_divide_count} + `SCU_FRAME_EXTRA - 9'h001;
   assign next_frame_pos = frame_pos >= frame_last ? 9'h000 : frame_pos + 9'h001;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         frame_pos <= 9'h000;
         internal_frame_pulse_out <= 1'b0;
      end else if (ser_tick) begin
         frame_pos <= next_frame_pos;
         if (ctrl[`SCU_BIT_PULSE_WIDE-12]) begin
            internal_frame_pulse_out <= next_frame_pos < `SCU_WIDE_PULSE_CLKS;
         end else begin
            internal_frame_pulse_out <= next_frame_pos == frame_last;
         end
      end
   end
endmodule

// [verification/scu_ctrl_properties.sv]
/* Port checks for the upper control bank, bound from the bench.
   Assumes one system clock and its asynchronous reset. */
`timescale 1ns/1ps
module scu_ctrl_properties (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic we_n_in,
   input wire logic [2:0] port_in,
   input wire logic port1_sel_in,
   input wire logic serial_en_in,
   input wire logic [19:0] ctrl_upper_out,
   input wire logic sclk_oe_out,
   input wire logic enc_en_out,
   input wire logic dec_en_out,
   input wire logic alaw_out,
   input wire logic twos_out,
   input wire logic word16_out,
   input wire logic parallel_mode_out,
   input wire logic codec_wr_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   sequence s_rise;
      !we_n_in ##1 we_n_in;
   endsequence
   sequence s_pulse;
      codec_wr_out ##1 !codec_wr_out;
   endsequence
   AST_RST: assert property ($rose(rstn_in) |-> ctrl_upper_out == 20'h00008)
      else $error("control bits not at reset image");
   AST_ENC: assert property (enc_en_out == ctrl_upper_out[0])
      else $error("encoder enable differs from bit");
   AST_DEC: assert property (dec_en_out == ctrl_upper_out[1])
      else $error("decoder enable differs from bit");
   AST_ALAW: assert property (alaw_out == ctrl_upper_out[2])
      else $error("law select differs from bit");
   AST_OE: assert property ($stable(ctrl_upper_out) |-> sclk_oe_out == !ctrl_upper_out[3])
      else $error("clock pin direction wrong");
   AST_TWOS: assert property (twos_out == ctrl_upper_out[17])
      else $error("format select differs from bit");
   AST_W16: assert property (word16_out == ctrl_upper_out[18])
      else $error("word length differs from bit");
   AST_PAR: assert property (parallel_mode_out == !$past(serial_en_in))
      else $error("parallel mode wrong");
   AST_LAT: assert property (s_rise ##0 (port_in == 3'h1 && !port1_sel_in) |-> ##5 s_pulse)
      else $error("routed write pulse missing");
   AST_NOWR: assert property (s_rise ##0 (port_in != 3'h1 || port1_sel_in) |-> ##5 !codec_wr_out)
      else $error("write routed wrongly");
endmodule

// [verification/scu_codec_model.sv]
/* Codec side of the serial clock pin: supplies the bit clock when the
   bank leaves the pin as input. Assumes the bank's enable and value. */
`timescale 1ns/1ps
module scu_codec_model (
   input wire logic run_in, // codec clock running
   input wire logic oe_in, // bank drives pin
   input wire logic dev_clk_in, // bank pin value
   output logic pin_out // resolved pin level
);
   logic gen = 1'b0;
   // Offset so pin edges never meet the system clock edge
   initial begin
      #5;
      forever #80 if (run_in) gen = ~gen;
   end
   assign pin_out = oe_in ? dev_clk_in : gen;
endmodule

// [verification/serial_companding_upper_control_tb_top.sv]
/* Bench for the upper control bank, one task per scenario.
   Assumes rtl/ on the include path and the codec model. */
`timescale 1ns/1ps
module serial_companding_upper_control_tb_top;
   logic clk_in = 1'b0, rstn_in = 1'b0, we_n_in = 1'b1, port1_sel_in = 1'b0;
   logic serial_en_in = 1'b0, codec_run = 1'b0;
   logic [2:0] port_in = 3'h0;
   logic [15:0] data_in = 16'h0000, codec_data_out;
   logic sclk_in, sclk_out, sclk_oe_out, internal_frame_pulse_out, enc_en_out, dec_en_out;
   logic alaw_out, twos_out, word16_out, parallel_mode_out, codec_wr_out;
   logic [19:0] ctrl_upper_out;
   int errors = 0, tests_run = 0, pulses = 0;
   scu_ctrl scu_ctrl_inst (.clk_in, .rstn_in, .we_n_in, .port_in, .data_in, .port1_sel_in,
      .serial_en_in, .sclk_in, .sclk_out, .sclk_oe_out, .internal_frame_pulse_out,
      .ctrl_upper_out, .enc_en_out, .dec_en_out, .alaw_out, .twos_out, .word16_out,
      .parallel_mode_out, .codec_wr_out, .codec_data_out);
   scu_codec_model scu_codec_model_inst (.run_in(codec_run), .oe_in(sclk_oe_out),
      .dev_clk_in(sclk_out), .pin_out(sclk_in));
   always #10 clk_in = ~clk_in;
   task automatic chk(input string s, input logic [19:0] e, input logic [19:0] g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   // Strobe phases kept long: the pin filter drops short ones
   task automatic wr(input logic [2:0] p, input logic [15:0] d);
      pulses = 0;
      @(negedge clk_in);
      we_n_in = 1'b0;
      port_in = p;
      data_in = d;
      repeat (5) @(negedge clk_in);
      we_n_in = 1'b1;
      repeat (8) begin
         @(negedge clk_in);
         if (codec_wr_out === 1'b1) pulses++;
      end
   endtask
   task automatic lvl(input logic v, output int n);
      n = 0;
      while (internal_frame_pulse_out !== v) begin
         @(negedge clk_in);
         n++;
         if (n > 5000) begin
            errors++;
            final_report();
         end
      end
   endtask
   // First rise may end a mixed frame, so measure from it onward
   task automatic frame(input int per, input int hi);
      int a, b;
      lvl(1'b0, a);
      lvl(1'b1, a);
      lvl(1'b0, a);
      lvl(1'b1, b);
      chk("pulse_high", 20'(hi), 20'(a));
      chk("frame_period", 20'(per), 20'(a + b));
   endtask
   task automatic t_reset();
      chk("ctrl_upper", 20'h00008, ctrl_upper_out);
      chk("oe_par_twos", 20'h2, {17'h0, sclk_oe_out, parallel_mode_out, twos_out});
   endtask
   task automatic t_low();
      logic [3:0] s;
      for (int i = 0; i < 4; i++) begin
         wr(3'h0, 16'h1000 << i);
         s = {!sclk_oe_out, alaw_out, dec_en_out, enc_en_out};
         chk("low_bits", 20'h1 << i, ctrl_upper_out);
         chk("settings", 20'h1 << i, {16'h0, s});
      end
   endtask
   task automatic t_upper();
      port1_sel_in = 1'b1;
      wr(3'h1, 16'h6000);
      chk("upper", 20'h60008, ctrl_upper_out);
      chk("twos_w16", 20'h3, {18'h0, word16_out, twos_out});
      chk("no_codec_wr", 20'h0, 20'(pulses));
   endtask
   task automatic t_route();
      port1_sel_in = 1'b0;
      serial_en_in = 1'b1;
      wr(3'h1, 16'ha5c3);
      chk("codec", 20'h1a5c3, {pulses[3:0], codec_data_out});
      chk("kept", 20'h60008, ctrl_upper_out);
      chk("par", 20'h0, {19'h0, parallel_mode_out});
      serial_en_in = 1'b0;
      wr(3'h5, 16'hffff);
      chk("other_port", 20'h60008, ctrl_upper_out);
   endtask
   task automatic t_frame();
      int n;
      logic s;
      port1_sel_in = 1'b1;
      wr(3'h0, 16'h0000);
      wr(3'h1, 16'h0007);
      frame(18, 2);
      wr(3'h1, 16'h1007);
      frame(18, 16);
      wr(3'h1, 16'h01fe);
      frame(1024, 4);
      // Code 1 halves every two system clocks
      n = 0;
      s = sclk_out;
      repeat (40) begin
         @(negedge clk_in);
         if (sclk_out !== s) n++;
         s = sclk_out;
      end
      chk("sclk_toggles", 20'h14, 20'(n));
      codec_run = 1'b1;
      wr(3'h0, 16'h8000);
      chk("sclk_ext", 20'h0, {18'h0, sclk_oe_out, sclk_out});
      frame(2048, 8);
   endtask
   initial begin
      repeat (16) @(negedge clk_in);
      rstn_in = 1'b1;
      t_reset();
      t_low();
      t_upper();
      t_route();
      t_frame();
      final_report();
   end
   task automatic final_report();
      if (errors == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
endmodule
bind scu_ctrl scu_ctrl_properties scu_ctrl_properties_inst (.clk_in, .rstn_in, .we_n_in,
   .port_in, .port1_sel_in, .serial_en_in, .ctrl_upper_out, .sclk_oe_out, .enc_en_out,
   .dec_en_out, .alaw_out, .twos_out, .word16_out, .parallel_mode_out, .codec_wr_out);
